// *** verif/fwg_core_model.sv ***
/* Core model: data writes and flash fetch bursts.
   Assumes the guard samples on rising clk_in. */
module fwg_core_model import fwg_pkg::*; (
  input wire logic clk_in,
  output logic fw_wr_out = 1'b0,
  output logic [ADDR_W-1:0] fw_addr_out = '0,
  output logic [7:0] fw_data_out = 8'h00,
  output logic fetch_out = 1'b0,
  output logic [ADDR_W-1:0] fetch_addr_out = '0
);
  // Released bus shows the inverse, so stale values cannot pass
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    fw_wr_out <= 1'b1;
    fw_addr_out <= a;
    fw_data_out <= d;
    @(posedge clk_in);
    fw_wr_out <= 1'b0;
    fw_addr_out <= ~a;
    fw_data_out <= ~d;
  endtask
  task automatic fetch(input logic [ADDR_W-1:0] a, input int n);
    @(posedge clk_in);
    fetch_out <= 1'b1;
    for (int i = 0; i < n; i++) begin
      fetch_addr_out <= a + ADDR_W'(i);
      @(posedge clk_in);
    end
    fetch_out <= 1'b0;
    fetch_addr_out <= ~a;
  endtask
endmodule // fwg_core_model

// *** verif/fwg_guard_bench.sv ***
/* Self-checking bench for fwg_guard with core model.
   Assumes OP_COUNT of 8 and the fwg_pkg register map. */
module fwg_guard_bench import fwg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, nrst_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, idle_req_in = 1'b0, irq_enable_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [NUM_IRQ-1:0] irq_req_in = 8'h00, irq_ack_in = 8'h00, irq_grant_out;
  logic [ADDR_W-1:0] fw_addr_in, fetch_addr_in, xram_addr_out, flash_addr_out;
  logic [7:0] fw_data_in, xram_data_out, flash_data_out;
  logic pready_out, pslverr_out, fw_wr_in, fetch_in, core_run_out, er;
  logic core_stall_out, xram_wr_out, flash_wr_out, flash_erase_out;
  logic sense_en_out, row_change_out, err_reset_out, irq_out;
  int err_total = 0, n_checks = 0, cyc = 0, n_sense = 0, n_row = 0;
  fwg_guard #(.OP_COUNT(8)) dut (.clk_in, .nrst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .fw_wr_in, .fw_addr_in, .fw_data_in, .fetch_in,
    .fetch_addr_in, .irq_req_in, .irq_ack_in, .irq_enable_in, .idle_req_in,
    .irq_grant_out, .core_run_out, .core_stall_out, .xram_wr_out,
    .xram_addr_out, .xram_data_out, .flash_wr_out, .flash_erase_out,
    .flash_addr_out, .flash_data_out, .sense_en_out, .row_change_out,
    .err_reset_out, .irq_out);
  fwg_core_model u_core (.clk_in, .fw_wr_out(fw_wr_in),
    .fw_addr_out(fw_addr_in), .fw_data_out(fw_data_in),
    .fetch_out(fetch_in), .fetch_addr_out(fetch_addr_in));
  always #12.5 clk_in = ~clk_in; // Single clock kept across writes
  always @(posedge clk_in) begin
    cyc++;
    if (sense_en_out === 1'b1) n_sense++;
    if (row_change_out === 1'b1) n_row++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s exp %h got %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    pwdata_in <= ~d;
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
      input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  task automatic bit1(input string n, input logic e, s);
    chk(n, {31'h0, e}, {31'h0, s});
  endtask
  task automatic do_reset();
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic arm(input logic [31:0] ctl);
    apb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
    apb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
    apb(1'b1, OFS_PROG_CTL, ctl);
  endtask
  task automatic t_regs();
    rchk("por_flags", OFS_RST_SRC, 32'hc2, 32'h82);
    rchk("prog_ctl", OFS_PROG_CTL, 32'h3, 32'h0);
    rchk("bypass", OFS_TIMING_CTL, 32'h40, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    bit1("unmapped", 1'b1, er);
  endtask
  task automatic t_sense();
    int s0, r0;
    s0 = n_sense;
    r0 = n_row;
    u_core.fetch(13'h003e, 4);
    repeat (3) @(posedge clk_in);
    chk("shot_len", SENSE_CYCLES, n_sense - s0);
    chk("row_cross", 32'h1, n_row - r0);
    apb(1'b1, OFS_TIMING_CTL, 32'h40);
    s0 = n_sense;
    r0 = n_row;
    u_core.fetch(13'h0044, 4);
    repeat (3) @(posedge clk_in);
    chk("bypass_len", 32'h4, n_sense - s0);
    chk("row_same", 32'h0, n_row - r0);
    do_reset();
    s0 = n_sense;
    u_core.fetch(13'h0044, 4);
    repeat (3) @(posedge clk_in);
    chk("rearm_len", SENSE_CYCLES, n_sense - s0);
  endtask
  task automatic t_write();
    irq_enable_in <= 1'b0;
    arm(32'h1);
    u_core.wr(13'h0105, 8'h3c);
    #1;
    bit1("flash_wr", 1'b1, flash_wr_out);
    bit1("stall", 1'b1, core_stall_out);
    chk("flash_addr", 32'h105, {19'h0, flash_addr_out});
    chk("flash_data", 32'h3c, {24'h0, flash_data_out});
    apb(1'b1, OFS_PROG_CTL, 32'h0);
    irq_enable_in <= 1'b1;
    irq_req_in <= 8'h04;
    @(posedge clk_in);
    irq_req_in <= 8'h00;
    repeat (2) @(posedge clk_in);
    #1;
    chk("held_grant", 32'h0, {24'h0, irq_grant_out});
    repeat (4) @(posedge clk_in);
    #1;
    chk("late_grant", 32'h4, {24'h0, irq_grant_out});
    @(posedge clk_in);
    irq_ack_in <= 8'h04;
    irq_enable_in <= 1'b0;
    @(posedge clk_in);
    irq_ack_in <= 8'h00;
    rchk("key_idle", OFS_KEY, 32'h3, 32'h0);
  endtask
  task automatic t_erase();
    arm(32'h3);
    u_core.wr(13'h0a47, 8'h12);
    #1;
    bit1("erase", 1'b1, flash_erase_out);
    bit1("erase_wr", 1'b0, flash_wr_out);
    chk("page_base", 32'ha00, {19'h0, flash_addr_out});
    chk("erase_data", 32'hff, {24'h0, flash_data_out});
    repeat (12) @(posedge clk_in);
    apb(1'b1, OFS_PROG_CTL, 32'h0);
    u_core.wr(13'h0123, 8'h5a);
    #1;
    bit1("xram_wr", 1'b1, xram_wr_out);
    bit1("xram_flash", 1'b0, flash_wr_out);
    chk("xram_data", 32'h5a, {24'h0, xram_data_out});
    chk("xram_addr", 32'h123, {19'h0, xram_addr_out});
  endtask
  task automatic t_lock_irq();
    apb(1'b1, OFS_PROG_CTL, 32'h1);
    u_core.wr(13'h0010, 8'h77);
    #1;
    bit1("no_key_wr", 1'b0, flash_wr_out);
    rchk("key_locked", OFS_KEY, 32'h3, 32'h3);
    bit1("irq_masked", 1'b0, irq_out);
    apb(1'b1, OFS_INT_MASK, 32'h2);
    repeat (2) @(posedge clk_in);
    #1;
    bit1("irq_on", 1'b1, irq_out);
    apb(1'b1, OFS_INT_STAT, 32'h2);
    repeat (2) @(posedge clk_in);
    #1;
    bit1("irq_clr", 1'b0, irq_out);
    rchk("int_stat", OFS_INT_STAT, 32'h7, 32'h1);
  endtask
  task automatic t_idle();
    @(posedge clk_in);
    idle_req_in <= 1'b1;
    @(posedge clk_in);
    idle_req_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    bit1("idle", 1'b0, core_run_out);
    @(posedge clk_in);
    irq_req_in <= 8'h01;
    @(posedge clk_in);
    irq_req_in <= 8'h00;
    repeat (2) @(posedge clk_in);
    #1;
    bit1("wake", 1'b1, core_run_out);
  endtask
  task automatic t_supply();
    do_reset();
    apb(1'b1, OFS_RST_SRC, 32'h2);
    apb(1'b1, OFS_MON_CTL, 32'h0);
    arm(32'h1);
    u_core.wr(13'h0200, 8'h11);
    #1;
    bit1("err_reset", 1'b1, err_reset_out);
    bit1("err_no_wr", 1'b0, flash_wr_out);
    repeat (3) @(posedge clk_in);
    rchk("err_flag", OFS_RST_SRC, 32'hc2, 32'hc0);
    rchk("en_clear", OFS_PROG_CTL, 32'h3, 32'h0);
    rchk("err_stat", OFS_INT_STAT, 32'h4, 32'h4);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_sense();
    t_write();
    t_erase();
    t_lock_irq();
    t_idle();
    t_supply();
    finish_test();
  end
endmodule // fwg_guard_bench

// *** verif/fwg_guard_chk.sv ***
/* Port assertions for the flash write guard.
   Bound into fwg_guard; offsets and fields from fwg_pkg. */
module fwg_guard_chk import fwg_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic fw_wr_in,
  input wire logic [ADDR_W-1:0] fw_addr_in,
  input wire logic [7:0] fw_data_in,
  input wire logic fetch_in,
  input wire logic [NUM_IRQ-1:0] irq_req_in,
  input wire logic [NUM_IRQ-1:0] irq_grant_out,
  input wire logic core_run_out,
  input wire logic core_stall_out,
  input wire logic xram_wr_out,
  input wire logic [ADDR_W-1:0] xram_addr_out,
  input wire logic [7:0] xram_data_out,
  input wire logic flash_wr_out,
  input wire logic flash_erase_out,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [7:0] flash_data_out,
  input wire logic sense_en_out,
  input wire logic err_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic byp;
  // Bypass mirror; error reset clears it on the guard's edge, $past covers the registered sense output
  always_ff @(posedge clk_in)
    if (!nrst_in || err_reset_out) byp <= 1'b0;
    else if (psel_in && penable_in && pready_out && pwrite_in &&
             paddr_in == OFS_TIMING_CTL) byp <= pwdata_in[BIT_BYPASS];
  property p_apb_wait;
    psel_in && penable_in && !pready_out |=> pready_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_xram;
    xram_wr_out |-> $past(fw_wr_in) && xram_addr_out == $past(fw_addr_in)
      && xram_data_out == $past(fw_data_in);
  endproperty
  a_xram: assert property (p_xram) else $error("xram write bad");
  property p_flash_wr;
    flash_wr_out |-> $past(fw_wr_in) && !flash_erase_out &&
      flash_addr_out == $past(fw_addr_in) && flash_data_out == $past(fw_data_in);
  endproperty
  a_flash_wr: assert property (p_flash_wr) else $error("flash write bad");
  property p_erase;
    flash_erase_out |-> $past(fw_wr_in) && flash_data_out == ERASED_BYTE &&
      (flash_addr_out >> PAGE_LSB) == ($past(fw_addr_in) >> PAGE_LSB) &&
      flash_addr_out[PAGE_LSB-1:0] == '0;
  endproperty
  a_erase: assert property (p_erase) else $error("erase bad");
  property p_err;
    err_reset_out |-> $past(fw_wr_in) && !flash_wr_out && !flash_erase_out;
  endproperty
  a_err: assert property (p_err) else $error("error reset bad");
  property p_stall;
    flash_wr_out || flash_erase_out |-> core_stall_out;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_defer;
    core_stall_out && $past(core_stall_out, 2) |->
      irq_grant_out == '0 || $past(irq_grant_out) != '0;
  endproperty
  a_defer: assert property (p_defer) else $error("grant in op");
  property p_shot_rise;
    $rose(fetch_in) && !byp |=> sense_en_out;
  endproperty
  a_shot_rise: assert property (p_shot_rise) else $error("no sense");
  property p_shot_len;
    !byp && !$past(byp) && sense_en_out |=> !sense_en_out;
  endproperty
  a_shot_len: assert property (p_shot_len) else $error("sense long");
  property p_bypass;
    byp && $past(byp) |-> sense_en_out == $past(fetch_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass bad");
  property p_wake;
    !core_run_out && irq_req_in != '0 |-> ##[1:3] core_run_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake late");
endmodule // fwg_guard_chk
bind fwg_guard fwg_guard_chk u_chk (.clk_in, .nrst_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .fw_wr_in, .fw_addr_in,
  .fw_data_in, .fetch_in, .irq_req_in, .irq_grant_out, .core_run_out,
  .core_stall_out, .xram_wr_out, .xram_addr_out, .xram_data_out,
  .flash_wr_out, .flash_erase_out, .flash_addr_out, .flash_data_out,
  .sense_en_out, .err_reset_out);

// *** verilog/fwg_guard.sv ***
/*
 * Flash write guard with read-power control: APB register file, key
 * lock, supply-monitor gate with flash error reset, flash operation
 * timing, interrupt deferral, idle wake and sense-amp one-shot.
 * Assumes the core's ports are on clk_in and nrst_in is power-on reset.
 */
module fwg_guard import fwg_pkg::*; #(
  parameter int OP_COUNT = OP_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fw_wr_in,
  input wire logic [ADDR_W-1:0] fw_addr_in,
  input wire logic [7:0] fw_data_in,
  input wire logic fetch_in,
  input wire logic [ADDR_W-1:0] fetch_addr_in,
  input wire logic [NUM_IRQ-1:0] irq_req_in,
  input wire logic [NUM_IRQ-1:0] irq_ack_in,
  input wire logic irq_enable_in,
  input wire logic idle_req_in,
  output logic [NUM_IRQ-1:0] irq_grant_out,
  output logic core_run_out,
  output logic core_stall_out,
  output logic xram_wr_out,
  output logic [ADDR_W-1:0] xram_addr_out,
  output logic [7:0] xram_data_out,
  output logic flash_wr_out,
  output logic flash_erase_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [7:0] flash_data_out,
  output logic sense_en_out,
  output logic row_change_out,
  output logic err_reset_out,
  output logic irq_out
);
  fwg_key_e key_state;
  logic flash_write_enable;
  logic flash_erase_enable;
  logic bypass;
  logic mon_en;
  logic mon_rst_en;
  logic power_on_reset_flag;
  logic flash_error_flag;
  logic [NUM_EV-1:0] int_stat;
  logic [NUM_EV-1:0] int_mask;
  logic op_busy;
  logic [15:0] op_count;
  logic idle;
  logic [ADDR_W-ROW_LSB-1:0] last_row;
  logic row_valid;
  logic err_pend;

  fwg_irq_if irq_bus ();

  // Bus decode
  wire logic apb_access = psel_in && penable_in && !pready_out;
  wire logic apb_wr = psel_in && penable_in && pready_out && pwrite_in;
  wire logic sel_prog = paddr_in == OFS_PROG_CTL;
  wire logic sel_timing = paddr_in == OFS_TIMING_CTL;
  wire logic sel_key = paddr_in == OFS_KEY;
  wire logic sel_rst = paddr_in == OFS_RST_SRC;
  wire logic sel_mon = paddr_in == OFS_MON_CTL;
  wire logic sel_stat = paddr_in == OFS_INT_STAT;
  wire logic sel_mask = paddr_in == OFS_INT_MASK;
  wire logic mapped = sel_prog || sel_timing || sel_key || sel_rst ||
    sel_mon || sel_stat || sel_mask;
  wire logic key_wr = apb_wr && sel_key;
  wire logic [7:0] key_byte = pwdata_in[7:0];

  // Read data mux; fields placed by position so the map lives in one place
  logic [31:0] rd_prog;
  logic [31:0] rd_timing;
  logic [31:0] rd_rst;
  logic [31:0] rd_mon;
  always_comb begin
    rd_prog = 32'h0;
    rd_prog[BIT_WR_EN] = flash_write_enable;
    rd_prog[BIT_ER_EN] = flash_erase_enable;
    rd_timing = 32'h0;
    rd_timing[BIT_BYPASS] = bypass;
    rd_rst = 32'h0;
    rd_rst[BIT_POR_FLAG] = power_on_reset_flag;
    rd_rst[BIT_FERR_FLAG] = flash_error_flag;
    rd_rst[BIT_MON_RST_EN] = mon_rst_en;
    rd_mon = 32'h0;
    rd_mon[BIT_MON_EN] = mon_en;
  end
  wire logic [31:0] rd_key = {30'h0, 2'(key_state)};
  wire logic [31:0] rd_stat = {29'h0, int_stat};
  wire logic [31:0] rd_mask = {29'h0, int_mask};
  wire logic [31:0] next_prdata =
    sel_prog ? rd_prog :
    sel_timing ? rd_timing :
    sel_key ? rd_key :
    sel_rst ? rd_rst :
    sel_mon ? rd_mon :
    sel_stat ? rd_stat :
    sel_mask ? rd_mask : 32'h0;

  // Core write steering
  // Core writes during a flash operation are dropped
  wire logic fw_accept = fw_wr_in && !op_busy && !err_pend;
  wire logic to_flash = fw_accept && flash_write_enable;
  wire logic to_xram = fw_accept && !flash_write_enable;
  wire logic supply_ok = mon_en && mon_rst_en;
  wire logic guard_trip = to_flash && !supply_ok;
  wire logic key_ok = key_state == KEY_ARMED;
  wire logic op_start = to_flash && supply_ok && key_ok;
  wire logic op_refused = to_flash && supply_ok && !key_ok;
  wire logic is_erase = flash_erase_enable;
  wire logic [ADDR_W-1:0] page_base =
    {fw_addr_in[ADDR_W-1:PAGE_LSB], PAGE_LSB'(0)};
  wire logic op_done = op_busy && op_count == 16'h0000;
  wire logic key_bad = key_wr && (key_state == KEY_ARMED ||
    (key_state == KEY_IDLE && key_byte != KEY_FIRST) ||
    (key_state == KEY_HALF && key_byte != KEY_SECOND));
  wire logic to_lock = key_bad || op_refused;

  // Row tracking for read current
  wire logic [ADDR_W-ROW_LSB-1:0] fetch_row = fetch_addr_in[ADDR_W-1:ROW_LSB];
  wire logic row_cross = fetch_in && row_valid && fetch_row != last_row;

  // Interrupt events
  wire logic [NUM_EV-1:0] ev;
  assign ev[EV_OP_DONE] = op_done;
  assign ev[EV_KEY_LOCK] = to_lock;
  assign ev[EV_FLASH_ERR] = guard_trip;
  wire logic [NUM_EV-1:0] stat_clr =
    (apb_wr && sel_stat) ? pwdata_in[NUM_EV-1:0] : '0;
  // Set wins over a same-cycle write-one clear
  wire logic [NUM_EV-1:0] next_int_stat = ev | (int_stat & ~stat_clr);

  // Idle and wake
  // Latched requests wake too, so a short pulse is not lost
  wire logic wake = |irq_req_in || irq_bus.any_pending;
  wire logic next_idle = (idle || idle_req_in) && !wake;

  assign irq_bus.raw = irq_req_in;
  assign irq_bus.ack = irq_ack_in;
  assign irq_bus.global_en = irq_enable_in;
  assign irq_bus.flash_busy = op_busy;

  fwg_irq_defer u_defer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .bus(irq_bus.defer)
  );

  // Device-reset shares the one-shot reset with power-on
  wire logic dev_nrst = nrst_in && !err_pend;
  wire logic sense_q;

  fwg_sense_oneshot u_sense (
    .clk_in(clk_in),
    .nrst_in(dev_nrst),
    .access_in(fetch_in),
    .bypass_in(bypass),
    .sense_en_out(sense_q)
  );
  assign sense_en_out = sense_q;

  // Bus slave
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      // One wait state keeps pready registered
      pready_out <= apb_access;
      pslverr_out <= apb_access && !mapped;
      if (apb_access)
        prdata_out <= next_prdata;
    end
  end

  // Power-on reset only: monitor enables and cause flags
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      mon_en <= 1'b1;
      mon_rst_en <= 1'b1;
      power_on_reset_flag <= 1'b1;
      flash_error_flag <= 1'b0;
    end else begin
      if (apb_wr && sel_mon)
        mon_en <= pwdata_in[BIT_MON_EN];
      // Direct write only; no read-modify-write path here
      if (apb_wr && sel_rst)
        mon_rst_en <= pwdata_in[BIT_POR_FLAG];
      if (err_pend) begin
        power_on_reset_flag <= 1'b0;
        flash_error_flag <= 1'b1;
      end
    end
  end

  // Device state cleared by any device reset
  always_ff @(posedge clk_in) begin
    if (!dev_nrst) begin
      flash_write_enable <= 1'b0;
      flash_erase_enable <= 1'b0;
      bypass <= 1'b0;
    end else begin
      if (apb_wr && sel_prog) begin
        flash_write_enable <= pwdata_in[BIT_WR_EN];
        flash_erase_enable <= pwdata_in[BIT_ER_EN];
      end
      if (apb_wr && sel_timing)
        bypass <= pwdata_in[BIT_BYPASS];
    end
  end

  // Key sequence; lock holds until a device reset
  always_ff @(posedge clk_in) begin
    if (!dev_nrst) begin
      key_state <= KEY_IDLE;
    end else begin
      unique case (key_state)
        KEY_IDLE: begin
          if (key_wr)
            key_state <= key_bad ? KEY_LOCKED : KEY_HALF;
          else if (op_refused)
            key_state <= KEY_LOCKED;
        end
        KEY_HALF: begin
          if (key_wr)
            key_state <= key_bad ? KEY_LOCKED : KEY_ARMED;
          else if (op_refused)
            key_state <= KEY_LOCKED;
        end
        KEY_ARMED: begin
          if (key_wr)
            key_state <= KEY_LOCKED;
          else if (op_done)
            key_state <= KEY_IDLE;
        end
        KEY_LOCKED: key_state <= KEY_LOCKED;
      endcase
    end
  end

  // Flash operation timing and error reset request
  always_ff @(posedge clk_in) begin
    if (!dev_nrst) begin
      op_busy <= 1'b0;
      op_count <= 16'h0000;
    end else if (op_start) begin
      op_busy <= 1'b1;
      op_count <= 16'(OP_COUNT - 1);
    end else if (op_done) begin
      op_busy <= 1'b0;
    end else if (op_busy) begin
      op_count <= op_count - 16'h0001;
    end
  end

  // Device reset follows the trip by a cycle; the write never lands
  always_ff @(posedge clk_in) begin
    if (!nrst_in)
      err_pend <= 1'b0;
    else
      err_pend <= guard_trip;
  end

  // Core-facing outputs
  always_ff @(posedge clk_in) begin
    if (!dev_nrst) begin
      xram_wr_out <= 1'b0;
      xram_addr_out <= '0;
      xram_data_out <= 8'h00;
      flash_wr_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_addr_out <= '0;
      flash_data_out <= 8'h00;
      core_stall_out <= 1'b0;
    end else begin
      xram_wr_out <= to_xram;
      if (to_xram) begin
        xram_addr_out <= fw_addr_in;
        xram_data_out <= fw_data_in;
      end
      flash_wr_out <= op_start && !is_erase;
      flash_erase_out <= op_start && is_erase;
      if (op_start) begin
        flash_addr_out <= is_erase ? page_base : fw_addr_in;
        flash_data_out <= is_erase ? ERASED_BYTE : fw_data_in;
      end
      core_stall_out <= op_start || (op_busy && !op_done);
    end
  end

  // Error reset pulse, idle, rows, interrupts
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      err_reset_out <= 1'b0;
      idle <= 1'b0;
      core_run_out <= 1'b1;
      last_row <= '0;
      row_valid <= 1'b0;
      row_change_out <= 1'b0;
      int_stat <= '0;
      int_mask <= INT_MASK_RST;
      irq_out <= 1'b0;
      irq_grant_out <= '0;
    end else begin
      err_reset_out <= guard_trip;
      idle <= next_idle;
      core_run_out <= !next_idle;
      if (fetch_in) begin
        last_row <= fetch_row;
        row_valid <= 1'b1;
      end
      row_change_out <= row_cross;
      int_stat <= next_int_stat;
      if (apb_wr && sel_mask)
        int_mask <= pwdata_in[NUM_EV-1:0];
      irq_out <= |(next_int_stat & int_mask);
      irq_grant_out <= irq_bus.grant;
    end
  end
endmodule // fwg_guard

// *** verilog/fwg_irq_defer.sv ***
/*
 * Interrupt deferral: latches requests, withholds grants while flash
 * is busy or interrupts are off, then grants the lowest index first.
 * Assumes the core acknowledges a grant with a one-cycle ack.
 */
module fwg_irq_defer import fwg_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  fwg_irq_if.defer bus
);
  logic [NUM_IRQ-1:0] pending;
  logic [NUM_IRQ-1:0] grant;
  wire logic [NUM_IRQ-1:0] lowest = pending & (~pending + 8'h01);
  wire logic may_grant = bus.global_en && !bus.flash_busy;
  assign bus.grant = grant;
  assign bus.any_pending = |pending;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pending <= '0;
      grant <= '0;
    end else begin
      // New request beats a same-cycle ack
      pending <= bus.raw | (pending & ~bus.ack);
      grant <= may_grant ? lowest : '0;
    end
  end
endmodule // fwg_irq_defer

// *** verilog/fwg_irq_if.sv ***
/*
 * Bundle between the guard top and its interrupt deferral unit.
 * Assumes both ends share one clock.
 */
interface fwg_irq_if;
  import fwg_pkg::*;
  logic [NUM_IRQ-1:0] raw;
  logic [NUM_IRQ-1:0] ack;
  logic global_en;
  logic flash_busy;
  logic [NUM_IRQ-1:0] grant;
  logic any_pending;
  modport ctl (output raw, output ack, output global_en, output flash_busy,
    input grant, input any_pending);
  modport defer (input raw, input ack, input global_en, input flash_busy,
    output grant, output any_pending);
endinterface

// *** verilog/fwg_pkg.sv ***
/*
 * Shared constants for the flash write guard: register offsets, field
 * positions, reset values, key bytes and timing counts.
 * Assumes a 40 MHz clock and a byte-wide flash of 8 kB.
 */
package fwg_pkg;
  localparam int CLK_MHZ = 40;
  localparam logic [7:0] OFS_PROG_CTL = 8'h00;
  localparam logic [7:0] OFS_TIMING_CTL = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_RST_SRC = 8'h0c;
  localparam logic [7:0] OFS_MON_CTL = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam int BIT_WR_EN = 0;
  localparam int BIT_ER_EN = 1;
  localparam int BIT_BYPASS = 6;
  localparam int BIT_POR_FLAG = 1;
  localparam int BIT_FERR_FLAG = 6;
  localparam int BIT_MON_RST_EN = 7;
  localparam int BIT_MON_EN = 0;
  localparam int EV_OP_DONE = 0;
  localparam int EV_KEY_LOCK = 1;
  localparam int EV_FLASH_ERR = 2;
  localparam int NUM_EV = 3;
  localparam int NUM_IRQ = 8;
  localparam int ADDR_W = 13;
  localparam int ROW_LSB = 6;
  localparam int PAGE_LSB = 9;
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [NUM_EV-1:0] INT_MASK_RST = 3'h0;
  localparam int OP_TIME_US = 20;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  localparam int SENSE_NS = 20;
  localparam int SENSE_CYCLES_RAW = (SENSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SENSE_CYCLES = (SENSE_CYCLES_RAW < 1) ? 1 : SENSE_CYCLES_RAW;
  localparam int WAKE_MAX_CYCLES = 3;
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED, KEY_LOCKED}
    fwg_key_e;
endpackage

// *** verilog/fwg_sense_oneshot.sv ***
/*
 * Sense-amplifier enable timer: a short pulse per flash access, or the
 * whole access when bypassed.
 * Assumes access and bypass come from logic on the same clock.
 */
module fwg_sense_oneshot import fwg_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic access_in,
  input wire logic bypass_in,
  output logic sense_en_out
);
  logic [7:0] count;
  logic access_d;
  wire logic start = access_in && !access_d;
  wire logic shot_live = count != 8'h00;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      count <= 8'h00;
      access_d <= 1'b0;
      sense_en_out <= 1'b0;
    end else begin
      access_d <= access_in;
      // Count restarts on every new access
      if (start)
        count <= 8'(SENSE_CYCLES - 1);
      else if (shot_live)
        count <= count - 8'h01;
      if (bypass_in)
        sense_en_out <= access_in;
      else
        sense_en_out <= start || (access_in && shot_live);
    end
  end
endmodule // fwg_sense_oneshot
